// ==== hdl/mies_pkg.sv ====
// constants, types and register map of the instruction execution block
// assumes a 32-bit classic wishbone master and one system clock
package mies_pkg;
    localparam logic [7:0] MIES_OFF_CMD = 8'h00;
    localparam logic [7:0] MIES_OFF_ACC = 8'h04;
    localparam logic [7:0] MIES_OFF_STAT = 8'h08;
    localparam logic [7:0] MIES_OFF_PC = 8'h0C;
    localparam logic [7:0] MIES_OFF_STK = 8'h10;
    localparam logic [7:0] MIES_OFF_MEM = 8'h40;
    localparam int MIES_EMI_BIT = 6;
    localparam logic [7:0] MIES_ACC_RST = 8'h00;
    localparam logic [7:0] MIES_ALL_ONES = 8'hFF;
    localparam logic [7:0] MIES_BIT0 = 8'h01;
    localparam logic MIES_EMI_RST = 1'b0;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_SUBROUTINE_RETURN = 5'h01,
        OP_RETURN_LITERAL = 5'h02,
        OP_INTERRUPT_RETURN = 5'h03,
        OP_OR_TO_MEMORY = 5'h04,
        OP_ROT_L = 5'h05,
        OP_ROT_L_ACC = 5'h06,
        OP_ROT_LC = 5'h07,
        OP_ROT_LC_ACC = 5'h08,
        OP_ROT_R = 5'h09,
        OP_ROT_R_ACC = 5'h0A,
        OP_ROT_RC = 5'h0B,
        OP_ROT_RC_ACC = 5'h0C,
        OP_SUB_BORROW_MEM = 5'h0D,
        OP_SUB_BORROW_IMM = 5'h0E,
        OP_SUB_BORROW_TO_MEMORY = 5'h0F,
        OP_DEC_SKIP_ZERO = 5'h10,
        OP_DEC_SKIP_ZERO_ACC = 5'h11,
        OP_INC_SKIP_ZERO = 5'h12,
        OP_INC_SKIP_ZERO_ACC = 5'h13,
        OP_SET_BYTE = 5'h14,
        OP_SET_BIT = 5'h15,
        OP_SKIP_BIT_NONZERO = 5'h16,
        OP_SKIP_IF_NONZERO = 5'h17
    } mies_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b10,
        ST_SERVICE = 2'b11
    } mies_state_t;

    typedef struct packed {
        logic comb_zero;
        logic sign_res;
        logic ovf;
        logic zero;
        logic aux_cy;
        logic carry;
    } mies_flags_t;

    localparam mies_flags_t MIES_FLG_RST = 6'h00;

    typedef struct packed {
        logic [7:0] lit;
        logic [7:0] addr;
        logic [4:0] rsv_hi;
        logic [2:0] bitn;
        logic [2:0] rsv_lo;
        mies_op_t op;
    } mies_cmd_t;

    typedef struct packed {
        logic [22:0] rsv;
        logic skip;
        logic busy;
        logic master_irq_enable;
        mies_flags_t flg;
    } mies_stat_t;
endpackage

// ==== hdl/mies_exec.sv ====
// execution unit for returns, rotates, subtract with borrow, set and skip ops
// assumes a classic wishbone master on clk; irq_pend comes from the irq controller
// Function
// - subroutine return pops stack into program counter, flags untouched.
// - literal return pops program counter and loads accumulator with immediate.
// - interrupt return pops program counter and sets master irq enable.
// - pending interrupt after interrupt return is serviced before main code resumes.
// - or to memory stores accumulator or byte into byte, zero flag only.
// - plain left rotate moves bit 7 to bit 0, no flags.
// - plain right rotate moves bit 0 to bit 7, no flags.
// - left rotate through carry is a nine bit ring, carry only.
// - right rotate through carry is a nine bit ring, carry only.
// - accumulator rotate variants write accumulator, memory byte untouched.
// - memory subtract with borrow: acc minus byte minus inverted carry into acc.
// - immediate subtract with borrow uses literal, result into accumulator.
// - memory destination subtract with borrow writes same difference to byte.
// - carry cleared when difference negative, set when zero or positive.
// - subtracts update overflow, zero, aux carry, carry, sign, combined zero.
// - decrement skip writes byte minus one, skips on zero, no flags.
// - increment skip writes byte plus one, skips on zero, no flags.
// - accumulator variants write accumulator only and skip on that result.
// - skip ops take two cycles, a dummy replaces the skipped instruction.
// - set byte writes all ones into the byte, no flags.
// - set bit forces only the selected bit to one, no flags.
// - bit test skips when the selected bit is one, no flags.
// - byte test writes the byte back and skips when nonzero.
//
// Our own choices: register access over Wishbone and the register addresses.
module mies_exec
    import mies_pkg::*;
#(
    parameter int PC_W = 12,
    parameter int STK_DEPTH = 8,
    parameter int MEM_DEPTH = 16,
    parameter logic [PC_W-1:0] IRQ_VECTOR = PC_W'(12'h004)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic irq_pend,
    output logic irq_ack_o
);
    localparam int MIW = $clog2(MEM_DEPTH), SPW = $clog2(STK_DEPTH);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    mies_state_t state_q;
    mies_cmd_t ir_q;
    mies_flags_t flg_q, flg_d;
    logic [7:0] acc_q;
    logic [PC_W-1:0] pc_q, pc_d, stk_top;
    logic [PC_W-1:0] stk_q [STK_DEPTH];
    logic [SPW-1:0] sp_q;
    logic [7:0] mem_q [MEM_DEPTH];
    logic [31:0] dat_q;
    logic emi_q, skip_q, ack_q, irq_ack_q, svc_take;

    // window onto the data memory, one byte per word
    function automatic logic mem_hit(input logic [7:0] a);
        return ({1'b0, a} >= {1'b0, MIES_OFF_MEM})
            && ({1'b0, a} < ({1'b0, MIES_OFF_MEM} + 9'(4 * MEM_DEPTH)));
    endfunction

    logic req, wr, idle, exe;
    logic wr_cmd, wr_acc, wr_stat, wr_pc, wr_stk, wr_mem;
    logic [MIW-1:0] bidx;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = req & wb_we_i;
    assign idle = state_q == ST_IDLE;
    assign exe = state_q == ST_EXEC;
    // software edits only while idle, so no write races the executing op
    assign wr_cmd = wr & idle & (wb_adr_i == MIES_OFF_CMD) & (&wb_sel_i);
    assign wr_acc = wr & idle & (wb_adr_i == MIES_OFF_ACC) & wb_sel_i[0];
    assign wr_stat = wr & idle & (wb_adr_i == MIES_OFF_STAT) & wb_sel_i[0];
    assign wr_pc = wr & idle & (wb_adr_i == MIES_OFF_PC) & (&wb_sel_i[1:0]);
    assign wr_stk = wr & idle & (wb_adr_i == MIES_OFF_STK) & (&wb_sel_i[1:0]);
    assign wr_mem = wr & idle & mem_hit(wb_adr_i) & wb_sel_i[0];
    assign bidx = wb_adr_i[MIW+1:2];
    assign stk_top = stk_q[sp_q - SPW'(1)];
    assign svc_take = (state_q == ST_SERVICE) & irq_pend & emi_q;

    // operand fetch and result formation
    logic [7:0] opnd, bsel, sub_b, mem_wd, acc_wd;
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic sub_ovf, mem_we, acc_we, do_pop, emi_set, skip, is_skip;

    assign opnd = mem_q[ir_q.addr[MIW-1:0]];
    assign bsel = MIES_BIT0 << ir_q.bitn;
    assign sub_b = (ir_q.op == OP_SUB_BORROW_IMM) ? ir_q.lit : opnd;
    // borrow is the inverted carry
    assign diff = {1'b0, acc_q} - {1'b0, sub_b} - {8'h00, ~flg_q.carry};
    assign ndiff = {1'b0, acc_q[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, ~flg_q.carry};
    assign sub_ovf = (acc_q[7] ^ sub_b[7]) & (acc_q[7] ^ diff[7]);

    always_comb begin
        mem_we = 1'b0;
        mem_wd = opnd;
        acc_we = 1'b0;
        acc_wd = acc_q;
        flg_d = flg_q;
        do_pop = 1'b0;
        emi_set = 1'b0;
        skip = 1'b0;
        is_skip = 1'b0;
        unique case (ir_q.op)
            OP_SUBROUTINE_RETURN: do_pop = 1'b1;
            OP_RETURN_LITERAL: begin
                do_pop = 1'b1;
                acc_we = 1'b1;
                acc_wd = ir_q.lit;
            end
            OP_INTERRUPT_RETURN: begin
                do_pop = 1'b1;
                emi_set = 1'b1;
            end
            OP_OR_TO_MEMORY: begin
                mem_we = 1'b1;
                mem_wd = acc_q | opnd;
                flg_d.zero = (acc_q | opnd) == 8'h00;
            end
            OP_ROT_L, OP_ROT_L_ACC: begin
                mem_wd = {opnd[6:0], opnd[7]};
                mem_we = ir_q.op == OP_ROT_L;
                acc_we = ir_q.op == OP_ROT_L_ACC;
                acc_wd = {opnd[6:0], opnd[7]};
            end
            OP_ROT_LC, OP_ROT_LC_ACC: begin
                mem_wd = {opnd[6:0], flg_q.carry};
                flg_d.carry = opnd[7];
                mem_we = ir_q.op == OP_ROT_LC;
                acc_we = ir_q.op == OP_ROT_LC_ACC;
                acc_wd = {opnd[6:0], flg_q.carry};
            end
            OP_ROT_R, OP_ROT_R_ACC: begin
                mem_wd = {opnd[0], opnd[7:1]};
                mem_we = ir_q.op == OP_ROT_R;
                acc_we = ir_q.op == OP_ROT_R_ACC;
                acc_wd = {opnd[0], opnd[7:1]};
            end
            OP_ROT_RC, OP_ROT_RC_ACC: begin
                mem_wd = {flg_q.carry, opnd[7:1]};
                flg_d.carry = opnd[0];
                mem_we = ir_q.op == OP_ROT_RC;
                acc_we = ir_q.op == OP_ROT_RC_ACC;
                acc_wd = {flg_q.carry, opnd[7:1]};
            end
            OP_SUB_BORROW_MEM, OP_SUB_BORROW_IMM, OP_SUB_BORROW_TO_MEMORY: begin
                mem_wd = diff[7:0];
                mem_we = ir_q.op == OP_SUB_BORROW_TO_MEMORY;
                acc_we = ir_q.op != OP_SUB_BORROW_TO_MEMORY;
                acc_wd = diff[7:0];
                flg_d.carry = ~diff[8];
                flg_d.aux_cy = ~ndiff[4];
                flg_d.ovf = sub_ovf;
                flg_d.zero = diff[7:0] == 8'h00;
                flg_d.sign_res = diff[7] ^ sub_ovf;
                // combined zero is set only if this byte is zero and the previous zero flag was set
                flg_d.comb_zero = (diff[7:0] == 8'h00) & flg_q.zero;
            end
            OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_ACC: begin
                is_skip = 1'b1;
                mem_wd = opnd - 8'h01;
                mem_we = ir_q.op == OP_DEC_SKIP_ZERO;
                acc_we = ir_q.op == OP_DEC_SKIP_ZERO_ACC;
                acc_wd = opnd - 8'h01;
                skip = (opnd - 8'h01) == 8'h00;
            end
            OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_ACC: begin
                is_skip = 1'b1;
                mem_wd = opnd + 8'h01;
                mem_we = ir_q.op == OP_INC_SKIP_ZERO;
                acc_we = ir_q.op == OP_INC_SKIP_ZERO_ACC;
                acc_wd = opnd + 8'h01;
                skip = (opnd + 8'h01) == 8'h00;
            end
            OP_SET_BYTE: begin
                mem_we = 1'b1;
                mem_wd = MIES_ALL_ONES;
            end
            OP_SET_BIT: begin
                mem_we = 1'b1;
                mem_wd = opnd | bsel;
            end
            OP_SKIP_BIT_NONZERO: begin
                is_skip = 1'b1;
                skip = |(opnd & bsel);
            end
            OP_SKIP_IF_NONZERO: begin
                is_skip = 1'b1;
                mem_we = 1'b1;
                mem_wd = opnd;
                skip = |opnd;
            end
            default: ;
        endcase
    end

    // a taken skip steps over one word; the dummy cycle hides the fetch
    assign pc_d = do_pop ? stk_top
        : pc_q + (skip ? PC_W'(2) : PC_W'(1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (wr_cmd) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (is_skip) begin
                        state_q <= ST_DUMMY;
                    end else if (ir_q.op == OP_INTERRUPT_RETURN) begin
                        state_q <= ST_SERVICE;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_DUMMY, ST_SERVICE: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ir_q <= '0;
        end else if (wr_cmd) begin
            ir_q <= mies_cmd_t'(wb_dat_i);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= '0;
        end else if (wr_pc) begin
            pc_q <= wb_dat_i[PC_W-1:0];
        end else if (exe) begin
            pc_q <= pc_d;
        end else if (svc_take) begin
            pc_q <= IRQ_VECTOR;
        end
    end

    // the stack wraps silently; software owns the depth budget
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sp_q <= '0;
            for (int i = 0; i < STK_DEPTH; i++) begin
                stk_q[i] <= '0;
            end
        end else if (exe && do_pop) begin
            sp_q <= sp_q - SPW'(1);
        end else if (wr_stk) begin
            stk_q[sp_q] <= wb_dat_i[PC_W-1:0];
            sp_q <= sp_q + SPW'(1);
        end else if (svc_take) begin
            stk_q[sp_q] <= pc_q;
            sp_q <= sp_q + SPW'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            emi_q <= MIES_EMI_RST;
        end else if (wr_stat) begin
            emi_q <= wb_dat_i[MIES_EMI_BIT];
        end else if (exe && emi_set) begin
            emi_q <= 1'b1;
        end else if (svc_take) begin
            emi_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flg_q <= MIES_FLG_RST;
        end else if (wr_stat) begin
            flg_q <= wb_dat_i[5:0];
        end else if (exe) begin
            flg_q <= flg_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= MIES_ACC_RST;
        end else if (wr_acc) begin
            acc_q <= wb_dat_i[7:0];
        end else if (exe && acc_we) begin
            acc_q <= acc_wd;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wr_mem) begin
            mem_q[bidx] <= wb_dat_i[7:0];
        end else if (exe && mem_we) begin
            mem_q[ir_q.addr[MIW-1:0]] <= mem_wd;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            skip_q <= 1'b0;
            irq_ack_q <= 1'b0;
        end else begin
            irq_ack_q <= svc_take;
            if (exe) begin
                skip_q <= skip;
            end
        end
    end

    // bus slave: one wait state, unmapped reads return zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req) begin
                if (mem_hit(wb_adr_i)) begin
                    dat_q <= {24'h00_0000, mem_q[bidx]};
                end else begin
                    unique case (wb_adr_i)
                        MIES_OFF_CMD: dat_q <= ir_q;
                        MIES_OFF_ACC: dat_q <= {24'h00_0000, acc_q};
                        MIES_OFF_STAT: dat_q <= {23'h00_0000, skip_q, ~idle, emi_q, flg_q};
                        MIES_OFF_PC: dat_q <= 32'(pc_q);
                        MIES_OFF_STK: dat_q <= 32'(sp_q);
                        default: dat_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq_ack_o = irq_ack_q;

    sequence s_exec_op(mies_op_t o);
        exe && ir_q.op == o;
    endsequence
    sequence s_dummy_then_idle;
        state_q == ST_DUMMY ##1 state_q == ST_IDLE;
    endsequence

    AST_RET_POP: assert property (s_exec_op(OP_SUBROUTINE_RETURN) |=>
        pc_q == $past(stk_top) && flg_q == $past(flg_q))
        else $error("subroutine return pc or flags wrong");
    AST_RET_LIT: assert property (s_exec_op(OP_RETURN_LITERAL) |=>
        acc_q == $past(ir_q.lit) && pc_q == $past(stk_top))
        else $error("literal return wrong");
    AST_INTERRUPT_RETURN_EMI: assert property (s_exec_op(OP_INTERRUPT_RETURN) |=> emi_q)
        else $error("master enable not set");
    AST_INTERRUPT_RETURN_SVC: assert property (s_exec_op(OP_INTERRUPT_RETURN) ##1 irq_pend |=>
        pc_q == IRQ_VECTOR && !emi_q && irq_ack_o)
        else $error("pending interrupt not serviced");
    AST_ORM: assert property (s_exec_op(OP_OR_TO_MEMORY) |=>
        opnd == $past(acc_q | opnd) && flg_q.carry == $past(flg_q.carry))
        else $error("or to memory wrong");
    AST_ROT_L: assert property (s_exec_op(OP_ROT_L) |=>
        opnd == {$past(opnd[6:0]), $past(opnd[7])})
        else $error("left rotate wrong");
    AST_ROT_RC: assert property (s_exec_op(OP_ROT_RC) |=>
        opnd == {$past(flg_q.carry), $past(opnd[7:1])} && flg_q.carry == $past(opnd[0]))
        else $error("right rotate through carry wrong");
    AST_ROT_ACC: assert property (s_exec_op(OP_ROT_LC_ACC) |=>
        $stable(opnd) && acc_q == {$past(opnd[6:0]), $past(flg_q.carry)})
        else $error("accumulator rotate touched memory");
    AST_SUB_CY: assert property (s_exec_op(OP_SUB_BORROW_IMM) |=>
        flg_q.carry == ({1'b0, $past(acc_q)} >= ({1'b0, $past(ir_q.lit)}
        + {8'h00, !$past(flg_q.carry)})))
        else $error("borrow carry wrong");
    AST_SKIP: assert property (exe && skip |=> s_dummy_then_idle)
        else $error("skip dummy cycle missing");
    AST_SET_BIT: assert property (s_exec_op(OP_SET_BIT) |=>
        opnd == ($past(opnd) | $past(bsel)) && flg_q == $past(flg_q))
        else $error("set bit wrong");
endmodule

// ==== sim/mies_exec_tb.sv ====
// self-checking bench for the instruction execution block
// assumes the block acks every classic wishbone cycle and shows busy in STAT bit 7
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module mies_exec_tb
    import mies_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] MEM_B = 8'h54;
    logic clk;
    logic rstn;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic ack;
    logic irq_pend;
    logic irq_ack;
    logic [31:0] d;
    int err_total;
    int checks;
    int irq_cnt;

    mies_exec i_dut (
        .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .irq_pend(irq_pend), .irq_ack_o(irq_ack)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (irq_ack === 1'b1) begin
            irq_cnt++;
        end
    end

    task automatic summarize();
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // request held until ack is sampled high; one idle cycle follows
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= wd;
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            err_total++;
            summarize();
        end
    endtask

    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e, m);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        `CHK(nm, e & m, r & m)
    endtask

    task automatic exec(input mies_op_t op, input logic [7:0] lit, input logic [2:0] bn);
        mies_cmd_t c;
        logic [31:0] r;
        int n;
        c = '{lit: lit, addr: 8'h05, rsv_hi: '0, bitn: bn, rsv_lo: '0, op: op};
        xfer(1'b1, MIES_OFF_CMD, 32'(c), r);
        n = 0;
        do begin
            xfer(1'b0, MIES_OFF_STAT, 32'h0000_0000, r);
            n++;
        end while (r[7] !== 1'b0 && n < 20);
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask

    task automatic run_op(input mies_op_t op, input logic [7:0] a, m, lit, input logic c,
                          input logic [2:0] bn);
        logic [7:0] r;
        logic [7:0] b;
        logic [7:0] ea;
        logic [7:0] em;
        logic [8:0] d9;
        logic [4:0] n5;
        logic es;
        mies_flags_t ef;
        ea = a;
        em = m;
        es = 1'b0;
        r = m;
        ef = '0;
        ef.carry = c;
        b = (op == OP_SUB_BORROW_IMM) ? lit : m;
        d9 = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
        n5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
        case (op)
            OP_OR_TO_MEMORY: r = a | m;
            OP_ROT_L, OP_ROT_L_ACC: r = {m[6:0], m[7]};
            OP_ROT_LC, OP_ROT_LC_ACC: r = {m[6:0], c};
            OP_ROT_R, OP_ROT_R_ACC: r = {m[0], m[7:1]};
            OP_ROT_RC, OP_ROT_RC_ACC: r = {c, m[7:1]};
            OP_SUB_BORROW_MEM, OP_SUB_BORROW_IMM, OP_SUB_BORROW_TO_MEMORY: r = d9[7:0];
            OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_ACC: r = m - 8'h01;
            OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_ACC: r = m + 8'h01;
            OP_SET_BYTE: r = MIES_ALL_ONES;
            OP_SET_BIT: r[bn] = 1'b1;
            default: r = m;
        endcase
        if (op inside {OP_ROT_LC, OP_ROT_LC_ACC}) ef.carry = m[7];
        if (op inside {OP_ROT_RC, OP_ROT_RC_ACC}) ef.carry = m[0];
        if (op inside {[OP_DEC_SKIP_ZERO:OP_INC_SKIP_ZERO_ACC]}) es = (r == 8'h00);
        if (op == OP_SKIP_BIT_NONZERO) es = m[bn];
        if (op == OP_SKIP_IF_NONZERO) es = (m != 8'h00);
        if (op == OP_OR_TO_MEMORY) ef.zero = (r == 8'h00);
        if (op inside {[OP_SUB_BORROW_MEM:OP_SUB_BORROW_TO_MEMORY]}) begin
            ef.carry = ~d9[8];
            ef.aux_cy = ~n5[4];
            ef.zero = (r == 8'h00);
            ef.ovf = (a[7] ^ b[7]) & (a[7] ^ r[7]);
            ef.sign_res = r[7] ^ ef.ovf;
        end
        if (op inside {OP_ROT_L_ACC, OP_ROT_LC_ACC, OP_ROT_R_ACC, OP_ROT_RC_ACC,
                       OP_SUB_BORROW_MEM, OP_SUB_BORROW_IMM, OP_DEC_SKIP_ZERO_ACC,
                       OP_INC_SKIP_ZERO_ACC}) begin
            ea = r;
        end else begin
            em = r;
        end
        xfer(1'b1, MIES_OFF_ACC, {24'h00_0000, a}, d);
        xfer(1'b1, MEM_B, {24'h00_0000, m}, d);
        xfer(1'b1, MIES_OFF_STAT, {31'h0000_0000, c}, d);
        xfer(1'b1, MIES_OFF_PC, 32'h0000_0100, d);
        exec(op, lit, bn);
        chk_rd("acc", MIES_OFF_ACC, {24'h00_0000, ea}, 32'h0000_00FF);
        chk_rd("mem", MEM_B, {24'h00_0000, em}, 32'h0000_00FF);
        chk_rd("flags", MIES_OFF_STAT, {26'h000_0000, ef}, 32'h0000_003F);
        chk_rd("skip", MIES_OFF_STAT, {23'h00_0000, es, 8'h00}, 32'h0000_0100);
        chk_rd("pc", MIES_OFF_PC, 32'h0000_0101 + 32'(es), 32'h0000_0FFF);
    endtask

    initial begin
        rstn = 1'b0;
        {cyc, stb, we, irq_pend} = 4'h0;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0000_0000;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        chk_rd("acc_rst", MIES_OFF_ACC, {24'h00_0000, MIES_ACC_RST}, 32'h0000_00FF);
        chk_rd("stat_rst", MIES_OFF_STAT, 32'h0000_0000, 32'h0000_01FF);
        chk_rd("unmapped", 8'h30, 32'h0000_0000, 32'hFFFF_FFFF);
        run_op(OP_OR_TO_MEMORY, 8'h00, 8'h00, 8'h00, 1'b0, 3'd0);
        run_op(OP_OR_TO_MEMORY, 8'h50, 8'h0A, 8'h00, 1'b1, 3'd0);
        run_op(OP_ROT_L, 8'h11, 8'h81, 8'h00, 1'b0, 3'd0);
        run_op(OP_ROT_R, 8'h11, 8'h81, 8'h00, 1'b1, 3'd0);
        run_op(OP_ROT_LC, 8'h11, 8'h81, 8'h00, 1'b0, 3'd0);
        run_op(OP_ROT_RC, 8'h11, 8'h82, 8'h00, 1'b1, 3'd0);
        run_op(OP_ROT_L_ACC, 8'h11, 8'h81, 8'h00, 1'b1, 3'd0);
        run_op(OP_ROT_R_ACC, 8'h11, 8'h81, 8'h00, 1'b0, 3'd0);
        run_op(OP_ROT_LC_ACC, 8'h11, 8'h41, 8'h00, 1'b1, 3'd0);
        run_op(OP_ROT_RC_ACC, 8'h11, 8'h81, 8'h00, 1'b0, 3'd0);
        run_op(OP_SUB_BORROW_MEM, 8'h10, 8'h20, 8'h00, 1'b1, 3'd0);
        run_op(OP_SUB_BORROW_MEM, 8'h20, 8'h1F, 8'h00, 1'b0, 3'd0);
        run_op(OP_SUB_BORROW_IMM, 8'h80, 8'h33, 8'h01, 1'b1, 3'd0);
        run_op(OP_SUB_BORROW_IMM, 8'h7F, 8'h00, 8'hFF, 1'b0, 3'd0);
        run_op(OP_SUB_BORROW_TO_MEMORY, 8'h05, 8'h03, 8'h00, 1'b1, 3'd0);
        run_op(OP_DEC_SKIP_ZERO, 8'h22, 8'h01, 8'h00, 1'b0, 3'd0);
        run_op(OP_DEC_SKIP_ZERO, 8'h22, 8'h00, 8'h00, 1'b1, 3'd0);
        run_op(OP_INC_SKIP_ZERO, 8'h22, 8'hFF, 8'h00, 1'b0, 3'd0);
        run_op(OP_INC_SKIP_ZERO, 8'h22, 8'h10, 8'h00, 1'b1, 3'd0);
        run_op(OP_DEC_SKIP_ZERO_ACC, 8'h22, 8'h01, 8'h00, 1'b0, 3'd0);
        run_op(OP_INC_SKIP_ZERO_ACC, 8'h00, 8'h7F, 8'h00, 1'b1, 3'd0);
        run_op(OP_SET_BYTE, 8'h22, 8'h12, 8'h00, 1'b1, 3'd0);
        run_op(OP_SET_BIT, 8'h22, 8'h00, 8'h00, 1'b0, 3'd5);
        run_op(OP_SKIP_BIT_NONZERO, 8'h22, 8'h20, 8'h00, 1'b0, 3'd5);
        run_op(OP_SKIP_BIT_NONZERO, 8'h22, 8'hEF, 8'h00, 1'b1, 3'd4);
        run_op(OP_SKIP_IF_NONZERO, 8'h22, 8'h00, 8'h00, 1'b0, 3'd0);
        run_op(OP_SKIP_IF_NONZERO, 8'h22, 8'h40, 8'h00, 1'b1, 3'd0);
        // zero result with old zero set: combined zero must come up
        xfer(1'b1, MIES_OFF_ACC, 32'h0000_0020, d);
        xfer(1'b1, MEM_B, 32'h0000_0020, d);
        xfer(1'b1, MIES_OFF_STAT, 32'h0000_0005, d);
        exec(OP_SUB_BORROW_MEM, 8'h00, 3'd0);
        chk_rd("cz_flg", MIES_OFF_STAT, 32'h0000_0027, 32'h0000_003F);
        xfer(1'b1, MIES_OFF_STAT, 32'h0000_0001, d);
        xfer(1'b1, MIES_OFF_STK, 32'h0000_02A3, d);
        exec(OP_SUBROUTINE_RETURN, 8'h00, 3'd0);
        chk_rd("ret_pc", MIES_OFF_PC, 32'h0000_02A3, 32'h0000_0FFF);
        chk_rd("ret_flg", MIES_OFF_STAT, 32'h0000_0001, 32'h0000_007F);
        xfer(1'b1, MIES_OFF_STK, 32'h0000_0155, d);
        exec(OP_RETURN_LITERAL, 8'h3C, 3'd0);
        chk_rd("retl_pc", MIES_OFF_PC, 32'h0000_0155, 32'h0000_0FFF);
        chk_rd("retl_acc", MIES_OFF_ACC, 32'h0000_003C, 32'h0000_00FF);
        chk_rd("retl_flg", MIES_OFF_STAT, 32'h0000_0001, 32'h0000_003F);
        xfer(1'b1, MIES_OFF_STK, 32'h0000_00AB, d);
        exec(OP_INTERRUPT_RETURN, 8'h00, 3'd0);
        chk_rd("interrupt_return_pc", MIES_OFF_PC, 32'h0000_00AB, 32'h0000_0FFF);
        chk_rd("interrupt_return_en", MIES_OFF_STAT, 32'h0000_0041, 32'h0000_007F);
        `CHK("irq_ack_idle", 0, irq_cnt)
        xfer(1'b1, MIES_OFF_STK, 32'h0000_00C7, d);
        irq_pend <= 1'b1;
        exec(OP_INTERRUPT_RETURN, 8'h00, 3'd0);
        irq_pend <= 1'b0;
        chk_rd("svc_pc", MIES_OFF_PC, 32'h0000_0004, 32'h0000_0FFF);
        chk_rd("svc_en", MIES_OFF_STAT, 32'h0000_0000, 32'h0000_0040);
        `CHK("irq_ack", 1, irq_cnt)
        exec(OP_SUBROUTINE_RETURN, 8'h00, 3'd0);
        chk_rd("main_pc", MIES_OFF_PC, 32'h0000_00C7, 32'h0000_0FFF);
        summarize();
    end
endmodule
